/* slpa_far_model.sv */
// Far side model: paired deserializer sending packets and reverse data
`timescale 1ns/1ns

module slpa_far_model (
	input  wire logic        core_clk,
	input  wire logic        send,
	input  wire logic        bad,
	input  wire logic [30:0] word,
	output logic      [31:0] rx_packet,
	output logic             rx_valid,
	output logic             reverse_in
);
	logic [31:0] last_q = 32'h0;
	logic [7:0]  lfsr_q = 8'h5A;

	// One wide packet per request; an idle bus shows a changing pattern, not stale data
	always @(posedge core_clk) begin
		rx_valid <= send;
		last_q <= send ? {^word ^ bad, word} : ~last_q;
		lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
		reverse_in <= lfsr_q[0];
	end
	assign rx_packet = last_q;
endmodule // slpa_far_model

/* slpa_framer.sv */
// Serial link payload framer with audio, parity, reverse channel and main clock
//
// Overview of operation
// - Width select low 24-bit, high 32-bit.
// - Encrypt color bits; never sync, valid, control.
// - Audio data encrypted only when carrying audio.
// - Even-parity bit ends each packet.
// - One packet slot carries forward control bit.
// - Reverse channel runs independent of forward control.
// - Reverse channel ready 500us after reset.
// - Reverse channel blanked 350us per link change.
// - Rate range high selects low-speed pixel clocks.
// - Rate range low selects high-speed pixel clocks.
// - Audio 8-192kHz, 4-32 bit words carried.
// - Async audio re-timed onto pixel clock stream.
// - Receive side passes the raw audio slot bit to output.
// - Audio on after reset; off means plain data.
// - Spread spectrum leaves audio rates unchanged.
// - Nonzero divider drives main clock on bit 28.
// - Main clock is source divided by 1-127; a ratio of 1 holds it high.
// - Main clock spread follows its source.
// - Mode select picks half or full duplex.
// - Bit 7 picks pixel multiple or oscillator source.
`timescale 1ns/1ns
`include "slpa_params.svh"

module slpa_framer
	import slpa_pkg::*;
#(
	parameter int POWERUP_CYC = `SLPA_POWERUP_CYC,
	parameter int LINKCHG_CYC = `SLPA_LINKCHG_CYC,
	parameter int TMR_W       = 13
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        width_select,
	input  wire logic        rate_range_select,
	input  wire logic        audio_enable,
	input  wire logic        encrypt_enable,
	input  wire logic [31:0] keystream,
	input  wire logic [28:0] din,
	input  wire logic        audio_sd,
	input  wire logic        audio_sck,
	input  wire logic        audio_ws,
	input  wire logic        forward_control_bit,
	output logic      [31:0] tx_packet,
	input  wire logic        link_active,
	input  wire logic        reverse_in,
	output logic             reverse_out,
	output logic             reverse_channel_ready,
	input  wire logic [31:0] rx_packet,
	input  wire logic        rx_valid,
	output logic      [28:0] dout,
	output logic             rx_audio_sd,
	output logic             rx_forward_control_bit,
	output logic             parity_error,
	input  wire logic        control_mode_select,
	output logic             control_full_duplex,
	input  wire logic        reg_write,
	input  wire logic  [7:0] reg_addr,
	input  wire logic  [7:0] reg_wdata,
	output logic       [7:0] reg_rdata,
	output logic             main_clock_source_select,
	output logic       [3:0] source_multiplier
);

	initial begin
		if (POWERUP_CYC < 1 || POWERUP_CYC >= (1 << TMR_W))
			$error("slpa_framer: POWERUP_CYC does not fit TMR_W");
		if (LINKCHG_CYC < 1 || LINKCHG_CYC >= (1 << TMR_W))
			$error("slpa_framer: LINKCHG_CYC does not fit TMR_W");
	end

	// ****************************************************************
	// Functions
	// ****************************************************************

	// Even parity over the bits that precede the parity slot
	function automatic logic slpa_parity(input logic [31:0] pkt, input logic wide);
		logic [31:0] m;
		m = wide ? {1'b0, pkt[30:0]} : {9'h000, pkt[22:0]};
		return ^m;
	endfunction

	// Bits of the parallel word that may be encrypted
	function automatic logic [28:0] slpa_enc_mask(input logic wide);
		return wide ? (`SLPA_ENC_BASE_MASK | `SLPA_ENC_WIDE_MASK) : `SLPA_ENC_BASE_MASK;
	endfunction

	// ****************************************************************
	// Register file
	// ****************************************************************
	logic [7:0] mclk_div_q;
	logic [7:0] mclk_div_d;
	logic [7:0] reg_rdata_q;
	logic [7:0] reg_rdata_d;
	logic       par_err_q;
	logic       par_err_d;
	logic       par_bad;
	logic       rc_ready_q;

	// Divider write, status readback; a parity fault beats a clear
	always_comb begin
		mclk_div_d = mclk_div_q;
		par_err_d  = par_err_q;
		if (reg_write && reg_addr == `SLPA_ADDR_MCLK_DIV) begin
			mclk_div_d = reg_wdata;
		end
		if (reg_write && reg_addr == `SLPA_ADDR_STATUS && reg_wdata[`SLPA_STAT_PARERR_BIT]) begin
			par_err_d = 1'b0;
		end
		if (par_bad) begin
			par_err_d = 1'b1;
		end
		reg_rdata_d = 8'h00;
		case (reg_addr)
			`SLPA_ADDR_MCLK_DIV: reg_rdata_d = mclk_div_q;
			`SLPA_ADDR_STATUS: begin
				reg_rdata_d[`SLPA_STAT_READY_BIT]  = rc_ready_q;
				reg_rdata_d[`SLPA_STAT_PARERR_BIT] = par_err_q;
			end
			default: reg_rdata_d = 8'h00;
		endcase
	end

	// Register flops
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mclk_div_q  <= `SLPA_MCLK_DIV_RESET;
			par_err_q   <= 1'b0;
			reg_rdata_q <= 8'h00;
		end else begin
			mclk_div_q  <= mclk_div_d;
			par_err_q   <= par_err_d;
			reg_rdata_q <= reg_rdata_d;
		end
	end

	// ****************************************************************
	// Audio re-timing
	// ****************************************************************
	logic sck_q;
	logic aud_bit_q;
	logic aud_bit_d;

	// Capture data XOR word select on each bit clock rise and hold it as a pixel-rate
	// stream; the pixel clock must oversample the bit clock for this
	always_comb begin
		aud_bit_d = aud_bit_q;
		if (audio_sck && !sck_q) begin
			aud_bit_d = audio_sd ^ audio_ws;
		end
	end

	// Audio flops
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sck_q     <= 1'b0;
			aud_bit_q <= 1'b0;
		end else begin
			sck_q     <= audio_sck;
			aud_bit_q <= aud_bit_d;
		end
	end

	// ****************************************************************
	// Transmit packet
	// ****************************************************************
	logic [31:0] tx_q;
	logic [31:0] tx_d;
	logic [28:0] data_w;
	logic        aud_slot;

	// Build one packet per pixel clock
	always_comb begin
		// Narrow mode drops inputs above bit 20
		data_w = din & (width_select ? `SLPA_WIDE_MASK : `SLPA_NARROW_MASK);
		if (encrypt_enable) begin
			data_w = data_w ^ (keystream[28:0] & slpa_enc_mask(width_select));
		end
		if (audio_enable) begin
			aud_slot = aud_bit_q ^ (encrypt_enable & keystream[`SLPA_W_AUDIO_BIT]);
		end else begin
			aud_slot = audio_sd;
		end
		tx_d = 32'h00000000;
		if (width_select) begin
			tx_d[28:0]                  = data_w;
			tx_d[`SLPA_W_AUDIO_BIT]     = aud_slot;
			tx_d[`SLPA_W_FCC_BIT]       = forward_control_bit;
			tx_d[`SLPA_W_PARITY_BIT]    = slpa_parity(tx_d, 1'b1);
		end else begin
			tx_d[20:0]                  = data_w[20:0];
			tx_d[`SLPA_N_AUDIO_BIT]     = aud_slot;
			tx_d[`SLPA_N_FCC_BIT]       = forward_control_bit;
			tx_d[`SLPA_N_PARITY_BIT]    = slpa_parity(tx_d, 1'b0);
		end
	end

	// Transmit flop
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tx_q <= 32'h00000000;
		end else begin
			tx_q <= tx_d;
		end
	end

	// ****************************************************************
	// Receive packet
	// ****************************************************************
	logic [28:0] dout_q;
	logic [28:0] dout_d;
	logic        rx_aud_q;
	logic        rx_aud_d;
	logic        rx_fcc_q;
	logic        rx_fcc_d;
	logic        rx_par;
	logic        mclk;

	// Check parity and unpack; bit 28 becomes the main clock when enabled
	always_comb begin
		dout_d   = dout_q;
		rx_aud_d = rx_aud_q;
		rx_fcc_d = rx_fcc_q;
		rx_par   = width_select ? rx_packet[`SLPA_W_PARITY_BIT] : rx_packet[`SLPA_N_PARITY_BIT];
		par_bad  = rx_valid && (slpa_parity(rx_packet, width_select) != rx_par);
		if (rx_valid) begin
			if (width_select) begin
				dout_d   = rx_packet[28:0];
				rx_aud_d = rx_packet[`SLPA_W_AUDIO_BIT];
				rx_fcc_d = rx_packet[`SLPA_W_FCC_BIT];
			end else begin
				dout_d   = {8'h00, rx_packet[20:0]};
				rx_aud_d = rx_packet[`SLPA_N_AUDIO_BIT];
				rx_fcc_d = rx_packet[`SLPA_N_FCC_BIT];
			end
		end
		if (mclk_div_q[`SLPA_DIV_MSB:0] != 7'h00) begin
			dout_d[`SLPA_MCLK_DATA_BIT] = mclk;
		end
	end

	// Receive flops
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			dout_q   <= 29'h00000000;
			rx_aud_q <= 1'b0;
			rx_fcc_q <= 1'b0;
		end else begin
			dout_q   <= dout_d;
			rx_aud_q <= rx_aud_d;
			rx_fcc_q <= rx_fcc_d;
		end
	end

	// Main clock divider; the source clock is modelled by core_clk
	slpa_mclk_div #(
		.DIV_W     (7)
	) u_mclk_div (
		.core_clk  (core_clk),
		.reset     (reset),
		.div_value (mclk_div_q[`SLPA_DIV_MSB:0]),
		.mclk      (mclk)
	);

	// ****************************************************************
	// Source select and mode outputs
	// ****************************************************************
	logic       src_sel_q;
	logic [3:0] mult_q;
	logic [3:0] mult_d;
	logic       duplex_q;

	// Source multiple follows rate and width; oscillator ignores both
	always_comb begin
		if (mclk_div_q[`SLPA_SRC_BIT]) begin
			mult_d = `SLPA_MULT_OSC;
		end else if (rate_range_select) begin
			mult_d = width_select ? `SLPA_MULT_LS_WIDE : `SLPA_MULT_LS_NARROW;
		end else begin
			mult_d = width_select ? `SLPA_MULT_HS_WIDE : `SLPA_MULT_HS_NARROW;
		end
	end

	// Mode flops
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			src_sel_q <= 1'b0;
			mult_q    <= `SLPA_MULT_OSC;
			duplex_q  <= 1'b0;
		end else begin
			src_sel_q <= mclk_div_q[`SLPA_SRC_BIT];
			mult_q    <= mult_d;
			duplex_q  <= control_mode_select;
		end
	end

	// ****************************************************************
	// Reverse control channel
	// ****************************************************************
	slpa_rc_state_t   rc_q;
	slpa_rc_state_t   rc_d;
	logic [TMR_W-1:0] tmr_q;
	logic [TMR_W-1:0] tmr_d;
	logic             link_q;
	logic             rc_ready_d;
	logic             rev_q;
	logic             rev_d;

	// Hold the channel off after reset and around each link start or stop
	always_comb begin
		rc_d  = rc_q;
		tmr_d = TMR_W'(tmr_q + 1'b1);
		case (rc_q)
			SLPA_RC_POWERUP: begin
				// A late link change outlasts the power-up wait, so blank from it
				if (link_active != link_q && int'(tmr_q) + LINKCHG_CYC >= POWERUP_CYC) begin
					rc_d  = SLPA_RC_BLANK;
					tmr_d = '0;
				end else if (tmr_q >= TMR_W'(POWERUP_CYC - 1)) begin
					rc_d  = SLPA_RC_READY;
					tmr_d = '0;
				end
			end
			SLPA_RC_BLANK: begin
				if (link_active != link_q) begin
					tmr_d = '0;
				end else if (tmr_q >= TMR_W'(LINKCHG_CYC - 1)) begin
					rc_d  = SLPA_RC_READY;
					tmr_d = '0;
				end
			end
			SLPA_RC_READY: begin
				tmr_d = '0;
				if (link_active != link_q) begin
					rc_d = SLPA_RC_BLANK;
				end
			end
			default: begin
				rc_d  = SLPA_RC_POWERUP;
				tmr_d = '0;
			end
		endcase
		rc_ready_d = (rc_d == SLPA_RC_READY);
		// Separate path from the forward control bit; idles high
		rev_d = rc_ready_d ? reverse_in : 1'b1;
	end

	// Reverse channel flops
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rc_q       <= SLPA_RC_POWERUP;
			tmr_q      <= '0;
			link_q     <= 1'b0;
			rc_ready_q <= 1'b0;
			rev_q      <= 1'b1;
		end else begin
			rc_q       <= rc_d;
			tmr_q      <= tmr_d;
			link_q     <= link_active;
			rc_ready_q <= rc_ready_d;
			rev_q      <= rev_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign tx_packet                = tx_q;
	assign dout                     = dout_q;
	assign rx_audio_sd              = rx_aud_q;
	assign rx_forward_control_bit   = rx_fcc_q;
	assign parity_error             = par_err_q;
	assign reg_rdata                = reg_rdata_q;
	assign reverse_out              = rev_q;
	assign reverse_channel_ready    = rc_ready_q;
	assign main_clock_source_select = src_sel_q;
	assign source_multiplier        = mult_q;
	assign control_full_duplex      = duplex_q;

endmodule // slpa_framer

/* slpa_framer_monitor.sv */
// Checker bound to the payload framer ports
`timescale 1ns/1ns
`include "slpa_params.svh"

module slpa_framer_monitor #(
	parameter int POWERUP_CYC = 20,
	parameter int LINKCHG_CYC = 10
) (
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic        width_select,
	input wire logic        encrypt_enable,
	input wire logic [31:0] keystream,
	input wire logic [28:0] din,
	input wire logic        audio_enable,
	input wire logic        audio_sd,
	input wire logic        audio_sck,
	input wire logic        audio_ws,
	input wire logic [31:0] tx_packet,
	input wire logic        link_active,
	input wire logic        reverse_in,
	input wire logic        reverse_out,
	input wire logic        reverse_channel_ready,
	input wire logic [31:0] rx_packet,
	input wire logic        rx_valid,
	input wire logic        parity_error,
	input wire logic        reg_write,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        main_clock_source_select
);
	logic [15:0] rst_cnt_q, rst_cnt_d, link_cnt_q, link_cnt_d;
	logic        link_q;

	// Saturating ages of reset release and of the last link change
	always_comb begin
		rst_cnt_d = (rst_cnt_q == 16'hFFFF) ? rst_cnt_q : rst_cnt_q + 16'h1;
		link_cnt_d = (link_cnt_q == 16'hFFFF) ? link_cnt_q : link_cnt_q + 16'h1;
		if (link_active != link_q)
			link_cnt_d = 16'h0;
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rst_cnt_q <= 16'h0;
			link_cnt_q <= 16'hFFFF;
			link_q <= 1'b0;
		end else begin
			rst_cnt_q <= rst_cnt_d;
			link_cnt_q <= link_cnt_d;
			link_q <= link_active;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	// ****************************************************************
	// Properties
	// ****************************************************************
	narrow_parity_a: assert property (!width_select |=>
		tx_packet[23] == ^tx_packet[22:0] && tx_packet[31:24] == 8'h00)
		else $error("narrow packet parity wrong");
	wide_parity_a: assert property (width_select |=>
		tx_packet[31] == ^tx_packet[30:0]) else $error("wide packet parity wrong");
	wide_cipher_a: assert property (width_select && encrypt_enable |=>
		tx_packet[28:0] == ($past(din) ^ ($past(keystream[28:0])
		& (`SLPA_ENC_BASE_MASK | `SLPA_ENC_WIDE_MASK)))) else $error("wide cipher wrong");
	narrow_cipher_a: assert property (!width_select |=>
		tx_packet[20:0] == ($past(din[20:0]) ^ ($past(keystream[20:0])
		& ($past(encrypt_enable) ? 21'h03FFFF : 21'h0)))) else $error("narrow data wrong");
	rev_follow_a: assert property ($past(reverse_channel_ready) && reverse_channel_ready
		|-> reverse_out == $past(reverse_in)) else $error("reverse data not passed");
	rev_idle_a: assert property (!reverse_channel_ready |-> reverse_out)
		else $error("reverse line not idle");
	audio_stream_a: assert property (audio_enable && audio_sck && !$past(audio_sck)
		##1 audio_enable |=> (($past(width_select) ? tx_packet[29] : tx_packet[21])
		== ($past(audio_sd, 2) ^ $past(audio_ws, 2) ^ ($past(encrypt_enable)
		& $past(keystream[29]))))) else $error("audio stream bit wrong");
	rev_blank_a: assert property (reverse_channel_ready |->
		link_cnt_q >= 16'(LINKCHG_CYC - 2) && rst_cnt_q >= 16'(POWERUP_CYC - 2))
		else $error("reverse channel ready too early");
	link_drop_a: assert property ($changed(link_active) |-> ##[1:2]
		!reverse_channel_ready) else $error("link change did not blank");
	parity_flag_a: assert property (rx_valid && width_select && ^rx_packet
		|-> ##[1:2] parity_error) else $error("bad parity not flagged");
	sticky_flag_a: assert property (parity_error && !(reg_write
		&& reg_addr == `SLPA_ADDR_STATUS) |=> parity_error) else $error("flag lost");
	mclk_src_a: assert property (reg_write && reg_addr == `SLPA_ADDR_MCLK_DIV
		##1 !reg_write [*2] |=> main_clock_source_select == $past(reg_wdata[7], 3))
		else $error("source select not stored");

endmodule // slpa_framer_monitor

bind slpa_framer slpa_framer_monitor #(.POWERUP_CYC(POWERUP_CYC), .LINKCHG_CYC(LINKCHG_CYC))
	u_slpa_framer_monitor (
	.core_clk(core_clk), .reset(reset), .width_select(width_select),
	.encrypt_enable(encrypt_enable), .keystream(keystream), .din(din),
	.audio_enable(audio_enable), .audio_sd(audio_sd), .audio_sck(audio_sck),
	.audio_ws(audio_ws), .tx_packet(tx_packet), .link_active(link_active),
	.reverse_in(reverse_in), .reverse_out(reverse_out),
	.reverse_channel_ready(reverse_channel_ready), .rx_packet(rx_packet),
	.rx_valid(rx_valid), .parity_error(parity_error), .reg_write(reg_write),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.main_clock_source_select(main_clock_source_select)
	);

/* slpa_framer_test.sv */
// Self-checking testbench for the payload framer
`timescale 1ns/1ns
`include "slpa_params.svh"

module slpa_framer_test;
	localparam int PU = 20;
	localparam int LC = 10;
	typedef struct {int when; logic [1:0] what; logic [31:0] val; logic [31:0] mask;} slpa_note_t;
	slpa_note_t  notes[$];
	logic        core_clk, reset, width_select, rate_range_select, audio_enable;
	logic        encrypt_enable, audio_sd, audio_sck, audio_ws, forward_control_bit;
	logic        link_active, reverse_in, reverse_out, reverse_channel_ready, rx_valid;
	logic        rx_audio_sd, rx_forward_control_bit, parity_error, control_mode_select;
	logic        control_full_duplex, reg_write, main_clock_source_select, send, bad, prev;
	logic [31:0] keystream, tx_packet, rx_packet, r, k, w;
	logic [28:0] din, dout, d;
	logic [30:0] word;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata;
	logic [3:0]  source_multiplier;
	int          n_fail, checks_done, n, cyc = 0;

	slpa_framer #(.POWERUP_CYC(PU), .LINKCHG_CYC(LC)) u_slpa_framer (.*);
	slpa_far_model u_slpa_far_model (.*);

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) cyc <= cyc + 1;

	task automatic tick(input int c);
		repeat (c) @(posedge core_clk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Drivers run at the edge before it counts itself, hence the extra cycle
	task automatic note(input int dl, input logic [1:0] wh, input logic [31:0] v,
			input logic [31:0] m);
		notes.push_back('{cyc + dl + 1, wh, v, m});
	endtask

	function automatic logic [31:0] seen(input logic [1:0] wh);
		case (wh)
			2'h0: return tx_packet;
			2'h1: return {24'h0, reg_rdata};
			2'h2: return {1'b0, rx_forward_control_bit, rx_audio_sd, dout};
			default: return {24'h0, parity_error, reverse_channel_ready,
				main_clock_source_select, source_multiplier, control_full_duplex};
		endcase
	endfunction

	// Expected packet; the audio slot carries raw data here and is masked when streaming
	function automatic logic [31:0] pkt(input logic wd, e, sd, f, input logic [28:0] dd,
			input logic [31:0] kk);
		logic [28:0] m;
		logic [31:0] p;
		m = e ? (`SLPA_ENC_BASE_MASK | (wd ? `SLPA_ENC_WIDE_MASK : 29'h0)) : 29'h0;
		dd = (dd ^ (kk[28:0] & m)) & (wd ? `SLPA_WIDE_MASK : `SLPA_NARROW_MASK);
		p = wd ? {1'b0, f, sd, dd} : {9'h0, f, sd, dd[20:0]};
		p[wd ? 31 : 23] = ^p;
		return p;
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr <= a;
		note(2, 2'h1, {24'h0, e}, '1);
		tick(3);
	endtask

	// Bounded wait for the reverse channel, counted in cycles
	task automatic wait_ready(input int lo, input int hi);
		n = 0;
		while (n < 200 && reverse_channel_ready !== 1'b1) begin
			@(negedge core_clk);
			n++;
		end
		chk(32'(n >= lo && n <= hi), 32'h1);
		if (n == 200)
			complete_run();
		@(posedge core_clk);
	endtask

	// Compare every note as its result falls due
	initial forever begin
		@(posedge core_clk);
		#1;
		while (notes.size() > 0 && notes[0].when <= cyc) begin
			chk(seen(notes[0].what) & notes[0].mask, notes[0].val & notes[0].mask);
			void'(notes.pop_front());
		end
	end

	initial begin
		tick(5000);
		n_fail++;
		complete_run();
	end

	initial begin
		reset = 1'b1;
		{width_select, rate_range_select, audio_enable, encrypt_enable, audio_sd} = 5'h0;
		{audio_sck, audio_ws, forward_control_bit, link_active, control_mode_select} = 5'h0;
		{reg_write, send, bad} = 3'h0;
		keystream = 32'h0;
		din = 29'h0;
		word = 31'h0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		n_fail = 0;
		checks_done = 0;
		void'($urandom(32'hC551B940));
		tick(5);
		reset <= 1'b0;
		wait_ready(PU - 1, PU + 2);
		// A second link change restarts the blanking time
		link_active <= 1'b1;
		note(1, 2'h3, 32'h0, 32'h40);
		tick(4);
		link_active <= 1'b0;
		wait_ready(LC, LC + 2);
		// Random words across widths, cipher, audio use and rate ranges
		for (int i = 0; i < 64; i++) begin
			r = $urandom;
			k = $urandom;
			d = 29'($urandom);
			{width_select, encrypt_enable, audio_enable, audio_sd, audio_sck, audio_ws} <= r[8:3];
			{forward_control_bit, rate_range_select, control_mode_select} <= r[2:0];
			din <= d;
			keystream <= k;
			note(1, 2'h0, pkt(r[8], r[7], r[5], r[2], d, k), r[6] ? (r[8] ?
				32'h5FFFFFFF : 32'hFF5FFFFF) : '1);
			note(1, 2'h3, {27'h0, r[1] ? (r[8] ? `SLPA_MULT_LS_WIDE : `SLPA_MULT_LS_NARROW)
				: (r[8] ? `SLPA_MULT_HS_WIDE : `SLPA_MULT_HS_NARROW), r[0]}, 32'h3F);
			@(posedge core_clk);
		end
		rd(8'h12, 8'h00);
		wr(8'h40, 8'hFF);
		rd(8'h40, 8'h00);
		rd(8'h12, 8'h00);
		wr(8'h12, 8'h85);
		rd(8'h12, 8'h85);
		note(0, 2'h3, 32'h20, 32'h3E);
		// Divided main clock on the top data bit, ratios kept well under the limit
		for (int dv = 2; dv < 6; dv++) begin
			wr(8'(dv), 8'h00);
			wr(8'h12, 8'(dv));
			tick(4);
			n = 0;
			prev = dout[28];
			repeat (120) begin
				@(negedge core_clk);
				n += int'(dout[28] & !prev);
				prev = dout[28];
			end
			chk(32'(n * dv >= 120 - dv && n * dv <= 120 + dv), 32'h1);
			@(posedge core_clk);
		end
		wr(8'h12, 8'h00);
		// Far side packets, the fourth with broken parity
		width_select <= 1'b1;
		encrypt_enable <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			w = $urandom;
			word <= w[30:0];
			bad <= (i == 3);
			send <= 1'b1;
			@(posedge core_clk);
			send <= 1'b0;
			note(1, 2'h2, {1'b0, w[30:0]}, '1);
			note(1, 2'h3, {24'h0, i >= 3, 7'h0}, 32'h80);
			@(posedge core_clk);
		end
		rd(8'h13, 8'h03);
		wr(8'h13, 8'h02);
		rd(8'h13, 8'h01);
		tick(3);
		complete_run();
	end
endmodule // slpa_framer_test

/* slpa_mclk_div.sv */
// Audio main clock divider
`timescale 1ns/1ns
`include "slpa_params.svh"

module slpa_mclk_div
	import slpa_pkg::*;
#(
	parameter int DIV_W = 7
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic [DIV_W-1:0] div_value,
	output logic                  mclk
);

	initial begin
		if (DIV_W < 1 || DIV_W > 16) $error("slpa_mclk_div: DIV_W out of range");
	end

	logic [DIV_W-1:0] cnt_q;
	logic [DIV_W-1:0] cnt_d;
	logic             mclk_q;
	logic             mclk_d;
	logic [DIV_W-1:0] half;

	// Divide by N; high for the first ceil(N/2) cycles of each period
	always_comb begin
		// One spare bit keeps the top ratio from wrapping to a zero half period
		half = DIV_W'(({1'b0, div_value} + 1'b1) >> 1);
		if (div_value == '0 || cnt_q >= DIV_W'(div_value - 1'b1)) begin
			cnt_d = '0;
		end else begin
			cnt_d = DIV_W'(cnt_q + 1'b1);
		end
		// A ratio of one cannot toggle faster than a flop, so it stays high
		mclk_d = (div_value != '0) && (cnt_d < half);
	end

	// Counter and output flops
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cnt_q  <= '0;
			mclk_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			mclk_q <= mclk_d;
		end
	end

	assign mclk = mclk_q;

endmodule // slpa_mclk_div

/* slpa_params.svh */
// Constants for the serial link payload and audio framer
`ifndef SLPA_PARAMS_SVH
`define SLPA_PARAMS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define SLPA_ADDR_MCLK_DIV    8'h12
`define SLPA_ADDR_STATUS      8'h13
`define SLPA_MCLK_DIV_RESET   8'h00
`define SLPA_DIV_MSB          6
`define SLPA_SRC_BIT          7
`define SLPA_STAT_READY_BIT   0
`define SLPA_STAT_PARERR_BIT  1

// ****************************************************************
// Packet layout
// ****************************************************************
`define SLPA_NARROW_MASK      29'h001FFFFF
`define SLPA_WIDE_MASK        29'h1FFFFFFF
`define SLPA_ENC_BASE_MASK    29'h0003FFFF
`define SLPA_ENC_WIDE_MASK    29'h07E00000
`define SLPA_N_AUDIO_BIT      21
`define SLPA_N_FCC_BIT        22
`define SLPA_N_PARITY_BIT     23
`define SLPA_W_AUDIO_BIT      29
`define SLPA_W_FCC_BIT        30
`define SLPA_W_PARITY_BIT     31
`define SLPA_MCLK_DATA_BIT    28

// ****************************************************************
// Main clock source multipliers
// ****************************************************************
`define SLPA_MULT_HS_NARROW   4'h3
`define SLPA_MULT_HS_WIDE     4'h4
`define SLPA_MULT_LS_NARROW   4'h6
`define SLPA_MULT_LS_WIDE     4'h8
`define SLPA_MULT_OSC         4'h0

// ****************************************************************
// Timing
// ****************************************************************
`define SLPA_CLK_MHZ          10
`define SLPA_POWERUP_US       500
`define SLPA_LINKCHG_US       350
`define SLPA_POWERUP_CYC      (`SLPA_POWERUP_US * `SLPA_CLK_MHZ)
`define SLPA_LINKCHG_CYC      (`SLPA_LINKCHG_US * `SLPA_CLK_MHZ)

`endif

/* slpa_pkg.sv */
// Types shared by the serial link payload and audio framer
package slpa_pkg;

	// Reverse control channel availability
	typedef enum logic [1:0] {
		SLPA_RC_POWERUP,
		SLPA_RC_BLANK,
		SLPA_RC_READY
	} slpa_rc_state_t;

endpackage
